// ### hw/cdp_pkg.sv
package cdp_pkg;
    localparam int NUM_CH = 8;
    localparam int RES_W = 16;
    localparam int STAT_W = 8;
    localparam int WORD_W = RES_W + STAT_W;
    localparam int FRAME_W = NUM_CH * WORD_W;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [NUM_CH-1:0] LANES_OFF = 8'hFF;
    localparam logic [NUM_CH-1:0] LANES_ON = 8'h00;
    // Lanes whose pins stay unused in the differential mode
    localparam logic [NUM_CH-1:0] LVDS_UNUSED_LANES = 8'h5A;
    localparam logic OE_OFF = 1'b1;
    localparam logic OE_ON = 1'b0;
    localparam logic [1:0] SYNC_RST = 2'h3;

    typedef enum logic [0:0] {
        CDP_BANK_IDLE = 1'b0,
        CDP_BANK_PEND = 1'b1
    } cdp_bank_t;
endpackage

// ### hw/cdp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_sync2 (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    import cdp_pkg::*;
    logic [1:0] sync_q;
    logic [1:0] sync_d;

    always_comb begin
        sync_d = {sync_q[0], async_in};
    end

    // Resets high: chip select read as inactive so bus disabled, mode read as LVDS
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_q <= SYNC_RST;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q[1];
endmodule
`default_nettype wire

// ### hw/cdp_port.sv
// Summary of operation
// - CMOS mode: each channel's result and optional status on its own lane, host clocked.
// - When selected in CMOS mode, first lane carries configuration read data during 4-wire reads.
// - CMOS host clock may idle high or low between transfers.
// - CMOS echo clock copies host clock, matched to lane data.
// - Echo disabled: CMOS echo clock output held high impedance.
// - LVDS: 100 ohm clock termination on while selected, unless disabled by control bit.
// - LVDS mode: unused CMOS lanes 1, 3, 4, 6 held high impedance.
// - LVDS: all results and status serialized on the single data pair.
// - LVDS echo clock pair matched to data, high impedance when echo disabled.
// - Data bus active only while chip select low, else high impedance.
`timescale 1ns/1ps
`default_nettype none
module cdp_port (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_data_clock_in,
    input wire logic cs_n,
    input wire logic lvds_mode,
    input wire logic echo_en,
    input wire logic term_dis,
    input wire logic status_en,
    input wire logic cfg_lane_sel,
    input wire logic cfg_rd_active,
    input wire logic cfg_rd_data,
    input wire logic result_valid,
    input wire logic [cdp_pkg::NUM_CH*cdp_pkg::RES_W-1:0] result_data,
    input wire logic [cdp_pkg::NUM_CH*cdp_pkg::STAT_W-1:0] status_data,
    output logic [cdp_pkg::NUM_CH-1:0] cmos_result_lanes,
    output logic [cdp_pkg::NUM_CH-1:0] cmos_lanes_oe_n,
    output logic echo_clock_out,
    output logic echo_clock_oe_n,
    output logic lvds_result_pair,
    output logic lvds_result_oe_n,
    output logic lvds_echo_clock_pair,
    output logic lvds_echo_oe_n,
    output logic lvds_term_en
);
    import cdp_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic cs_n_s;
    logic lvds_s;

    cdp_sync2 u_sync_cs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(cs_n),
        .sync_out(cs_n_s)
    );

    cdp_sync2 u_sync_mode (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(lvds_mode),
        .sync_out(lvds_s)
    );

    // ************************************************************
    // Result bank, system domain
    // ************************************************************
    // Bank only changes while deselected, so the link side sees it static
    logic [FRAME_W-1:0] bank_q;
    logic [FRAME_W-1:0] bank_d;
    logic [FRAME_W-1:0] stage_q;
    logic [FRAME_W-1:0] stage_d;
    cdp_bank_t bst_q;
    cdp_bank_t bst_d;

    function automatic logic [FRAME_W-1:0] pack_frame(
        input logic [NUM_CH*RES_W-1:0] res,
        input logic [NUM_CH*STAT_W-1:0] st,
        input logic st_en
    );
        logic [FRAME_W-1:0] f;
        f = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            f[c*WORD_W +: WORD_W] = {res[c*RES_W +: RES_W], st_en ? st[c*STAT_W +: STAT_W] : {STAT_W{1'b0}}};
        end
        return f;
    endfunction

    always_comb begin
        bank_d = bank_q;
        stage_d = stage_q;
        bst_d = bst_q;
        if (result_valid) begin
            stage_d = pack_frame(result_data, status_data, status_en);
        end
        case (bst_q)
            CDP_BANK_IDLE: begin
                if (result_valid) begin
                    if (cs_n_s) begin
                        bank_d = stage_d;
                    end else begin
                        bst_d = CDP_BANK_PEND;
                    end
                end
            end
            CDP_BANK_PEND: begin
                if (cs_n_s) begin
                    bank_d = stage_d;
                    bst_d = CDP_BANK_IDLE;
                end
            end
            default: begin
                bst_d = CDP_BANK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bank_q <= '0;
            stage_q <= '0;
            bst_q <= CDP_BANK_IDLE;
        end else begin
            bank_q <= bank_d;
            stage_q <= stage_d;
            bst_q <= bst_d;
        end
    end

    // ************************************************************
    // Output enables and termination, system domain
    // ************************************************************
    logic [NUM_CH-1:0] lane_oe_q;
    logic [NUM_CH-1:0] lane_oe_d;
    logic echo_oe_q;
    logic echo_oe_d;
    logic lvds_oe_q;
    logic lvds_oe_d;
    logic lvds_echo_oe_q;
    logic lvds_echo_oe_d;
    logic term_q;
    logic term_d;

    always_comb begin
        lane_oe_d = LANES_OFF;
        echo_oe_d = OE_OFF;
        lvds_oe_d = OE_OFF;
        lvds_echo_oe_d = OE_OFF;
        term_d = 1'b0;
        if (!cs_n_s) begin
            if (lvds_s) begin
                lane_oe_d = LANES_OFF | LVDS_UNUSED_LANES;
                lvds_oe_d = OE_ON;
                lvds_echo_oe_d = echo_en ? OE_ON : OE_OFF;
                term_d = !term_dis;
            end else begin
                lane_oe_d = LANES_ON;
                echo_oe_d = echo_en ? OE_ON : OE_OFF;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lane_oe_q <= LANES_OFF;
            echo_oe_q <= OE_OFF;
            lvds_oe_q <= OE_OFF;
            lvds_echo_oe_q <= OE_OFF;
            term_q <= 1'b0;
        end else begin
            lane_oe_q <= lane_oe_d;
            echo_oe_q <= echo_oe_d;
            lvds_oe_q <= lvds_oe_d;
            lvds_echo_oe_q <= lvds_echo_oe_d;
            term_q <= term_d;
        end
    end

    assign cmos_lanes_oe_n = lane_oe_q;
    assign echo_clock_oe_n = echo_oe_q;
    assign lvds_result_oe_n = lvds_oe_q;
    assign lvds_echo_oe_n = lvds_echo_oe_q;
    assign lvds_term_en = term_q;

    // ************************************************************
    // Link domain: bit counter on the host clock
    // ************************************************************
    // Chip select high clears the counter: the host clock may stop between frames
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 8'h01;
    end

    // Only rising edges count, so idle level of the clock is irrelevant
    always_ff @(posedge host_data_clock_in or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    function automatic logic pick_bit(input logic [FRAME_W-1:0] f, input int idx);
        logic b;
        b = 1'b0;
        if (idx >= 0 && idx < FRAME_W) begin
            b = f[idx];
        end
        return b;
    endfunction

    // Lanes are muxed from stable bank bits; a flop here would cost the first bit
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            cmos_result_lanes[c] = pick_bit(bank_q, c*WORD_W + WORD_W - 1 - int'(cnt_q));
        end
        if (cfg_lane_sel && cfg_rd_active) begin
            cmos_result_lanes[0] = cfg_rd_data;
        end
        lvds_result_pair = pick_bit(bank_q, FRAME_W - 1 - int'(cnt_q));
    end

    // Echo is the host clock itself, same path length as the data
    assign echo_clock_out = host_data_clock_in;
    assign lvds_echo_clock_pair = host_data_clock_in;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_bus_off;
        @(posedge clk_sys) disable iff (!rst_n) cs_n_s |=> (cmos_lanes_oe_n == LANES_OFF) && lvds_result_oe_n;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven while deselected");

    property p_lvds_lanes;
        @(posedge clk_sys) disable iff (!rst_n) lvds_s |=> (cmos_lanes_oe_n & LVDS_UNUSED_LANES) == LVDS_UNUSED_LANES;
    endproperty
    a_lvds_lanes: assert property (p_lvds_lanes) else $error("unused lane driven in lvds mode");

    property p_echo_off;
        @(posedge clk_sys) disable iff (!rst_n) !echo_en |=> echo_clock_oe_n && lvds_echo_oe_n;
    endproperty
    a_echo_off: assert property (p_echo_off) else $error("echo driven while disabled");

    property p_echo_on;
        @(posedge clk_sys) disable iff (!rst_n) (!cs_n_s && !lvds_s && echo_en) |=> !echo_clock_oe_n;
    endproperty
    a_echo_on: assert property (p_echo_on) else $error("cmos echo not driven");

    property p_lvds_echo;
        @(posedge clk_sys) disable iff (!rst_n) (!cs_n_s && lvds_s) |=> (lvds_echo_oe_n == !$past(echo_en));
    endproperty
    a_lvds_echo: assert property (p_lvds_echo) else $error("lvds echo enable wrong");

    property p_term;
        @(posedge clk_sys) disable iff (!rst_n) ##1 lvds_term_en == ($past(lvds_s) && !$past(cs_n_s) && !$past(term_dis));
    endproperty
    a_term: assert property (p_term) else $error("termination state wrong");

    property p_cmos_lanes;
        @(posedge clk_sys) disable iff (!rst_n) (!cs_n_s && !lvds_s) |=> cmos_lanes_oe_n == LANES_ON && lvds_result_oe_n;
    endproperty
    a_cmos_lanes: assert property (p_cmos_lanes) else $error("cmos lanes not driven");

    property p_lvds_data;
        @(posedge clk_sys) disable iff (!rst_n) (!cs_n_s && lvds_s) |=> !lvds_result_oe_n;
    endproperty
    a_lvds_data: assert property (p_lvds_data) else $error("lvds pair not driven");

    property p_bank_hold;
        @(posedge clk_sys) disable iff (!rst_n) (!cs_n_s && !$past(cs_n_s)) |=> $stable(bank_q) || $past(cs_n_s);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank changed during frame");

    property p_pend_load;
        @(posedge clk_sys) disable iff (!rst_n) (bst_q == CDP_BANK_PEND && cs_n_s) |=> bank_q == $past(stage_d);
    endproperty
    a_pend_load: assert property (p_pend_load) else $error("pending result not loaded");

    c_cmos_frame: cover property (@(posedge clk_sys) disable iff (!rst_n) !cs_n_s && !lvds_s ##4 cs_n_s);
    c_lvds_frame: cover property (@(posedge clk_sys) disable iff (!rst_n) !cs_n_s && lvds_s && echo_en);
    c_pend: cover property (@(posedge clk_sys) disable iff (!rst_n) bst_q == CDP_BANK_PEND ##1 bst_q == CDP_BANK_IDLE);
endmodule
`default_nettype wire

// ### testbench/cdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side: frames the link and shifts results in
// ****
module cdp_host_model (
    output logic host_data_clock_in,
    output logic cs_n,
    input wire logic [cdp_pkg::NUM_CH-1:0] cmos_result_lanes,
    input wire logic lvds_result_pair,
    input wire logic echo_clock_out,
    input wire logic lvds_echo_clock_pair
);
    import cdp_pkg::*;
    logic [23:0] cap [NUM_CH];
    logic [191:0] ser;
    int echo_bad = 0;
    initial begin
        host_data_clock_in = 1'b0;
        cs_n = 1'b1;
    end
    // Odd offset keeps the link phase unrelated to clk_sys
    task automatic sel(input logic lo, input logic idle);
        host_data_clock_in = idle;
        #13 cs_n = lo;
        #300;
    endtask
    // Clock stands still outside frames; sample just before each rise
    task automatic shift(input int n, input logic idle);
        for (int k = 0; k < n; k++) begin
            host_data_clock_in = 1'b0;
            #62.5;
            for (int c = 0; c < NUM_CH; c++) cap[c] = {cap[c][22:0], cmos_result_lanes[c]};
            ser = {ser[190:0], lvds_result_pair};
            host_data_clock_in = 1'b1;
            #1 if (echo_clock_out !== 1'b1 || lvds_echo_clock_pair !== 1'b1) echo_bad++;
            #61.5;
        end
        host_data_clock_in = idle;
        #62.5;
    endtask
endmodule
`default_nettype wire

// ### testbench/conversion_data_output_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench: host model on the link, control pins from here
// ****
module conversion_data_output_port_tb;
    import cdp_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, lvds_mode = 1'b0, echo_en = 1'b1, term_dis = 1'b0;
    logic status_en = 1'b1, cfg_lane_sel = 1'b0, cfg_rd_active = 1'b0, cfg_rd_data = 1'b0, result_valid = 1'b0;
    logic [NUM_CH*RES_W-1:0] result_data = '0;
    logic [NUM_CH*STAT_W-1:0] status_data = '0;
    logic host_data_clock_in, cs_n, echo_clock_out, echo_clock_oe_n, lvds_result_pair, lvds_result_oe_n;
    logic lvds_echo_clock_pair, lvds_echo_oe_n, lvds_term_en;
    logic [NUM_CH-1:0] cmos_result_lanes, cmos_lanes_oe_n;
    logic [191:0] fr;
    logic [7:0] salt = 8'h3C;
    int miscompares = 0, n_tests = 0, cycles = 0;
    always #25 clk_sys = ~clk_sys;
    cdp_port DUT (.clk_sys, .rst_n, .host_data_clock_in, .cs_n, .lvds_mode, .echo_en, .term_dis, .status_en,
        .cfg_lane_sel, .cfg_rd_active, .cfg_rd_data, .result_valid, .result_data, .status_data,
        .cmos_result_lanes, .cmos_lanes_oe_n, .echo_clock_out, .echo_clock_oe_n, .lvds_result_pair,
        .lvds_result_oe_n, .lvds_echo_clock_pair, .lvds_echo_oe_n, .lvds_term_en);
    cdp_host_model host (.host_data_clock_in, .cs_n, .cmos_result_lanes, .lvds_result_pair,
        .echo_clock_out, .lvds_echo_clock_pair);
    task automatic chk(input string what, input logic [191:0] exp, input logic [191:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [23:0] word(input int c);
        return {result_data[c*RES_W+:RES_W], status_en ? status_data[c*STAT_W+:STAT_W] : 8'h00};
    endfunction
    // Bank takes it at once only while deselected; else it waits for the frame end
    task automatic load(input logic st, input logic md, input logic ec, input logic td);
        @(negedge clk_sys);
        for (int c = 0; c < NUM_CH; c++) begin
            result_data[c*RES_W+:RES_W] = 16'h9C5A ^ {4'(c), 4'(c), salt};
            status_data[c*STAT_W+:STAT_W] = 8'hA0 | 8'(c);
        end
        status_en = st;
        lvds_mode = md;
        echo_en = ec;
        term_dis = td;
        result_valid = 1'b1;
        @(negedge clk_sys) result_valid = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic t_cmos(input logic idle, input logic st, input logic ec);
        load(st, 1'b0, ec, 1'b0);
        host.sel(1'b0, idle);
        chk("lanes_oe", LANES_ON, cmos_lanes_oe_n);
        chk("echo_oe", ec ? OE_ON : OE_OFF, echo_clock_oe_n);
        host.shift(24, idle);
        for (int c = 0; c < NUM_CH; c++) chk("lane", word(c), host.cap[c]);
        chk("echo", 0, host.echo_bad);
        host.sel(1'b1, idle);
        chk("lanes_off", LANES_OFF, cmos_lanes_oe_n);
        chk("echo_off", OE_OFF, echo_clock_oe_n);
    endtask
    task automatic t_cfg;
        @(negedge clk_sys);
        cfg_lane_sel = 1'b1;
        cfg_rd_active = 1'b1;
        host.sel(1'b0, 1'b0);
        for (int v = 0; v < 2; v++) begin
            @(negedge clk_sys) cfg_rd_data = v[0];
            #1 chk("cfg_lane", v[0], cmos_result_lanes[0]);
        end
        @(negedge clk_sys) cfg_rd_active = 1'b0;
        host.sel(1'b1, 1'b0);
    endtask
    task automatic t_lvds(input logic ec, input logic td);
        load(1'b1, 1'b1, ec, td);
        for (int c = 0; c < NUM_CH; c++) fr[c*24+:24] = word(c);
        host.sel(1'b0, 1'b0);
        chk("unused", LVDS_UNUSED_LANES, cmos_lanes_oe_n & LVDS_UNUSED_LANES);
        chk("term", !td, lvds_term_en);
        chk("ser_oe", OE_ON, lvds_result_oe_n);
        chk("lecho_oe", ec ? OE_ON : OE_OFF, lvds_echo_oe_n);
        host.shift(192, 1'b0);
        chk("serial", fr, host.ser);
        chk("lecho", 0, host.echo_bad);
        host.sel(1'b1, 1'b0);
        chk("term_off", 0, lvds_term_en);
        chk("ser_off", OE_OFF, lvds_result_oe_n);
    endtask
    // New results during a frame must wait for deselect
    task automatic t_pend;
        for (int c = 0; c < NUM_CH; c++) fr[c*24+:24] = word(c);
        host.sel(1'b0, 1'b0);
        salt = 8'hC3;
        load(1'b1, 1'b0, 1'b1, 1'b0);
        host.shift(24, 1'b0);
        for (int c = 0; c < NUM_CH; c++) chk("lane_held", fr[c*24+:24], host.cap[c]);
        host.sel(1'b1, 1'b0);
        host.sel(1'b0, 1'b0);
        host.shift(24, 1'b0);
        for (int c = 0; c < NUM_CH; c++) chk("lane_pend", word(c), host.cap[c]);
        host.sel(1'b1, 1'b0);
        chk("pend_off", LANES_OFF, cmos_lanes_oe_n);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ****
    // Watchdog
    // ****
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        t_cmos(1'b0, 1'b1, 1'b1);
        t_cmos(1'b1, 1'b0, 1'b0);
        t_cfg();
        t_pend();
        t_lvds(1'b1, 1'b0);
        t_lvds(1'b0, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
